// ===== hw/pusl_top.sv
// Power-up strap latch: samples board straps and turns them into configuration
//
// Overview of operation
// - The override strap is latched at core power-good rise; 0 keeps security, 1 disables it.
// - A latched override halts the management controller after bring-up and disables runtime features.
// - The port B detect strap is latched at core power-good rise; 1 means present.
// - The port C detect strap is latched at core power-good rise; 1 means present.
// - The port D detect strap is latched at core power-good rise; 1 means present.
// - Weak pull-downs on override and port straps are on while sampling, off after platform reset ends.
// - The reserved strap pull-down is released after resume reset deasserts.
`timescale 1ns/1ps
`default_nettype none
module pusl_top
	import pusl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PUSL_ADDR_W-1:0] paddr,
	input wire logic [PUSL_DATA_W-1:0] pwdata,
	output logic [PUSL_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power and reset sequencing
	input wire logic core_power_good,
	input wire logic resume_reset_n,
	input wire logic platform_reset_n,
	input wire logic bringup_done,
	// Strap pins
	input wire logic descriptor_override_strap,
	input wire logic port_b_detect_strap,
	input wire logic port_c_detect_strap,
	input wire logic port_d_detect_strap,
	input wire logic reserved_low_strap,
	// Weak pull-down controls
	output logic strap_pulldown_en,
	output logic reserved_pulldown_en,
	// Configuration outputs
	output logic security_override,
	output logic port_b_present,
	output logic port_c_present,
	output logic port_d_present,
	output logic reserved_strap_error,
	output logic mgmt_halt,
	output logic mgmt_run,
	output logic runtime_mgmt_disable
);
	// ----------------------------------------
	// Sampling events
	// ----------------------------------------
	logic core_rise;
	logic core_fall;
	logic rsm_rise;
	logic rsm_fall;
	logic plat_rise;

	pusl_edge u_core_edge (
		.clk(clk),
		.reset(reset),
		.level(core_power_good),
		.rise(core_rise),
		.fall(core_fall)
	);

	pusl_edge u_rsm_edge (
		.clk(clk),
		.reset(reset),
		.level(resume_reset_n),
		.rise(rsm_rise),
		.fall(rsm_fall)
	);

	pusl_edge u_plat_edge (
		.clk(clk),
		.reset(reset),
		.level(platform_reset_n),
		.rise(plat_rise),
		.fall()
	);

	// ----------------------------------------
	// Core power-good straps
	// ----------------------------------------
	logic override_reg;
	logic port_b_reg;
	logic port_c_reg;
	logic port_d_reg;
	logic core_valid_reg;

	// Loaded only on the edge, so later pin wiggles cannot leak in
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			override_reg <= PUSL_STRAP_DEFAULT;
			port_b_reg <= PUSL_STRAP_DEFAULT;
			port_c_reg <= PUSL_STRAP_DEFAULT;
			port_d_reg <= PUSL_STRAP_DEFAULT;
			core_valid_reg <= 1'b0;
		end else if (core_rise) begin
			override_reg <= descriptor_override_strap;
			port_b_reg <= port_b_detect_strap;
			port_c_reg <= port_c_detect_strap;
			port_d_reg <= port_d_detect_strap;
			core_valid_reg <= 1'b1;
		end
	end

	assign security_override = override_reg;
	assign port_b_present = port_b_reg;
	assign port_c_present = port_c_reg;
	assign port_d_present = port_d_reg;
	assign runtime_mgmt_disable = override_reg;

	// ----------------------------------------
	// Resume reset strap
	// ----------------------------------------
	logic reserved_reg;
	logic rsm_valid_reg;
	logic err_reg;
	pusl_if u_if ();

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reserved_reg <= PUSL_STRAP_DEFAULT;
			rsm_valid_reg <= 1'b0;
		end else if (rsm_rise) begin
			reserved_reg <= reserved_low_strap;
			rsm_valid_reg <= 1'b1;
		end
	end

	// A high sample is flagged; a new hit wins over a software clear
	wire err_set = rsm_rise & reserved_low_strap;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err_reg <= 1'b0;
		end else if (err_set) begin
			err_reg <= 1'b1;
		end else if (u_if.err_clear) begin
			err_reg <= 1'b0;
		end
	end

	assign reserved_strap_error = err_reg;

	// ----------------------------------------
	// Weak pull-downs
	// ----------------------------------------
	logic pd_main_reg;
	logic pd_rsv_reg;

	// Re-armed when power drops, so the next sampling window is covered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pd_main_reg <= PUSL_PD_RESET;
		end else if (plat_rise) begin
			pd_main_reg <= 1'b0;
		end else if (core_fall) begin
			pd_main_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pd_rsv_reg <= PUSL_PD_RESET;
		end else if (rsm_rise) begin
			pd_rsv_reg <= 1'b0;
		end else if (rsm_fall) begin
			pd_rsv_reg <= 1'b1;
		end
	end

	assign strap_pulldown_en = pd_main_reg;
	assign reserved_pulldown_en = pd_rsv_reg;

	// ----------------------------------------
	// Management controller sequencing
	// ----------------------------------------
	pusl_mgmt_t mg_reg;
	pusl_mgmt_t mg_next;

	always_comb begin
		mg_next = mg_reg;
		case (mg_reg)
			PUSL_MG_IDLE: begin
				if (core_rise) begin
					mg_next = PUSL_MG_BRINGUP;
				end
			end
			PUSL_MG_BRINGUP: begin
				if (core_fall) begin
					mg_next = PUSL_MG_IDLE;
				end else if (bringup_done) begin
					mg_next = override_reg ? PUSL_MG_HALT : PUSL_MG_RUN;
				end
			end
			PUSL_MG_RUN, PUSL_MG_HALT: begin
				if (core_fall) begin
					mg_next = PUSL_MG_IDLE;
				end
			end
			default: begin
				mg_next = PUSL_MG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mg_reg <= PUSL_MG_IDLE;
		end else begin
			mg_reg <= mg_next;
		end
	end

	// Software can stop a running controller but never lift a halt
	assign mgmt_halt = (mg_reg == PUSL_MG_HALT);
	assign mgmt_run = (mg_reg == PUSL_MG_RUN) & u_if.mgmt_enable;

	// ----------------------------------------
	// Register block
	// ----------------------------------------
	always_comb begin
		u_if.status = '0;
		u_if.status[PUSL_ST_OVERRIDE] = override_reg;
		u_if.status[PUSL_ST_PORT_B] = port_b_reg;
		u_if.status[PUSL_ST_PORT_C] = port_c_reg;
		u_if.status[PUSL_ST_PORT_D] = port_d_reg;
		u_if.status[PUSL_ST_RESERVED] = reserved_reg;
		u_if.status[PUSL_ST_HALT] = mgmt_halt;
		u_if.status[PUSL_ST_PD_MAIN] = pd_main_reg;
		u_if.status[PUSL_ST_PD_RSV] = pd_rsv_reg;
		u_if.status[PUSL_ST_CORE_VALID] = core_valid_reg;
		u_if.status[PUSL_ST_RSM_VALID] = rsm_valid_reg;
	end

	assign u_if.err_flag = err_reg;

	pusl_apb u_apb (
		.clk(clk),
		.reset(reset),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.regs(u_if.bus)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_override_latch: assert property (@(posedge clk) disable iff (reset)
		core_rise |=> security_override == $past(descriptor_override_strap))
		else $error("override strap not latched at power-good rise");

	chk_port_b_latch: assert property (@(posedge clk) disable iff (reset)
		core_rise |=> port_b_present == $past(port_b_detect_strap))
		else $error("port B strap not latched");

	chk_port_c_latch: assert property (@(posedge clk) disable iff (reset)
		core_rise |=> port_c_present == $past(port_c_detect_strap))
		else $error("port C strap not latched");

	chk_port_d_latch: assert property (@(posedge clk) disable iff (reset)
		core_rise |=> port_d_present == $past(port_d_detect_strap))
		else $error("port D strap not latched");

	chk_halt_after_bringup: assert property (@(posedge clk) disable iff (reset)
		(mg_reg == PUSL_MG_BRINGUP) && bringup_done && !core_fall && override_reg
		|=> mgmt_halt && !mgmt_run && runtime_mgmt_disable)
		else $error("management controller not halted under override");

	chk_pulldown_release: assert property (@(posedge clk) disable iff (reset)
		plat_rise |=> !strap_pulldown_en ##1 (strap_pulldown_en == $past(core_fall)))
		else $error("strap pull-down not released after platform reset");

	chk_reserved_sample: assert property (@(posedge clk) disable iff (reset)
		rsm_rise && reserved_low_strap |=> reserved_strap_error [*2])
		else $error("reserved strap high sample not flagged");

	chk_reserved_release: assert property (@(posedge clk) disable iff (reset)
		rsm_rise |=> !reserved_pulldown_en)
		else $error("reserved pull-down not released");

	chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
		!core_rise && !rsm_rise |=> $stable({security_override, port_b_present,
			port_c_present, port_d_present, reserved_reg}))
		else $error("latched strap changed without a sampling edge");
endmodule : pusl_top
`default_nettype wire

// ===== pkg/pusl_pkg.sv
// Package: constants for the power-up strap latch
package pusl_pkg;
	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int PUSL_ADDR_W = 8;
	localparam int PUSL_DATA_W = 32;
	localparam int PUSL_STAT_W = 10;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [PUSL_ADDR_W-1:0] PUSL_STATUS_OFS = 8'h00;
	localparam logic [PUSL_ADDR_W-1:0] PUSL_CTRL_OFS = 8'h04;
	localparam logic [PUSL_ADDR_W-1:0] PUSL_ERR_OFS = 8'h08;
	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int PUSL_ST_OVERRIDE = 0;
	localparam int PUSL_ST_PORT_B = 1;
	localparam int PUSL_ST_PORT_C = 2;
	localparam int PUSL_ST_PORT_D = 3;
	localparam int PUSL_ST_RESERVED = 4;
	localparam int PUSL_ST_HALT = 5;
	localparam int PUSL_ST_PD_MAIN = 6;
	localparam int PUSL_ST_PD_RSV = 7;
	localparam int PUSL_ST_CORE_VALID = 8;
	localparam int PUSL_ST_RSM_VALID = 9;
	// ----------------------------------------
	// Control / error fields and reset values
	// ----------------------------------------
	localparam int PUSL_CTRL_MGMT_EN = 0;
	localparam int PUSL_ERR_RSV_HIGH = 0;
	localparam logic PUSL_STRAP_DEFAULT = 1'b0;
	localparam logic PUSL_PD_RESET = 1'b1;
	localparam logic PUSL_MGMT_EN_RESET = 1'b1;
	localparam logic PUSL_EDGE_PREV_RESET = 1'b0;
	localparam logic [PUSL_DATA_W-1:0] PUSL_ZERO_WORD = 32'h0000_0000;
	// ----------------------------------------
	// Management controller states (Gray along idle-bringup-run)
	// ----------------------------------------
	typedef enum logic [1:0] {
		PUSL_MG_IDLE = 2'h0,
		PUSL_MG_BRINGUP = 2'h1,
		PUSL_MG_RUN = 2'h3,
		PUSL_MG_HALT = 2'h2
	} pusl_mgmt_t;
endpackage : pusl_pkg

// ===== pkg/pusl_if.sv
// Interface: status and control between the strap core and its APB slave
`timescale 1ns/1ps
`default_nettype none
interface pusl_if;
	import pusl_pkg::*;
	logic [PUSL_STAT_W-1:0] status;
	logic err_flag;
	logic mgmt_enable;
	logic err_clear;
	modport core (output status, output err_flag, input mgmt_enable, input err_clear);
	modport bus (input status, input err_flag, output mgmt_enable, output err_clear);
endinterface : pusl_if
`default_nettype wire

// ===== hw/pusl_edge.sv
// Edge detector: one-cycle pulses on rise and fall of a synchronous level
`timescale 1ns/1ps
`default_nettype none
module pusl_edge
	import pusl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Level in
	input wire logic level,
	// Pulses out
	output logic rise,
	output logic fall
);
	logic prev_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_reg <= PUSL_EDGE_PREV_RESET;
		end else begin
			prev_reg <= level;
		end
	end

	assign rise = level & ~prev_reg;
	assign fall = ~level & prev_reg;
endmodule : pusl_edge
`default_nettype wire

// ===== hw/pusl_apb.sv
// APB slave: status, control and error registers of the strap latch
`timescale 1ns/1ps
`default_nettype none
module pusl_apb
	import pusl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PUSL_ADDR_W-1:0] paddr,
	input wire logic [PUSL_DATA_W-1:0] pwdata,
	output logic [PUSL_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	pusl_if.bus regs
);
	function automatic logic is_reg(input logic [PUSL_ADDR_W-1:0] a,
		input logic [PUSL_ADDR_W-1:0] ofs);
		is_reg = (a == ofs);
	endfunction : is_reg

	logic mgmt_en_reg;
	logic [PUSL_DATA_W-1:0] prdata_reg;
	logic [PUSL_DATA_W-1:0] rd_next;
	wire hit_status = is_reg(paddr, PUSL_STATUS_OFS);
	wire hit_ctrl = is_reg(paddr, PUSL_CTRL_OFS);
	wire hit_err = is_reg(paddr, PUSL_ERR_OFS);
	wire mapped = hit_status | hit_ctrl | hit_err;
	wire setup = psel & ~penable;
	wire wr_done = psel & penable & pready & pwrite & mapped;

	// Zero wait states: data is fetched in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_reg;
	assign regs.mgmt_enable = mgmt_en_reg;
	assign regs.err_clear = wr_done & hit_err & pwdata[PUSL_ERR_RSV_HIGH];

	always_comb begin
		rd_next = PUSL_ZERO_WORD;
		if (hit_status) begin
			rd_next[PUSL_STAT_W-1:0] = regs.status;
		end else if (hit_ctrl) begin
			rd_next[PUSL_CTRL_MGMT_EN] = mgmt_en_reg;
		end else if (hit_err) begin
			rd_next[PUSL_ERR_RSV_HIGH] = regs.err_flag;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_reg <= PUSL_ZERO_WORD;
		end else if (setup) begin
			prdata_reg <= rd_next;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mgmt_en_reg <= PUSL_MGMT_EN_RESET;
		end else if (wr_done & hit_ctrl) begin
			mgmt_en_reg <= pwdata[PUSL_CTRL_MGMT_EN];
		end
	end
endmodule : pusl_apb
`default_nettype wire

// ===== testbench/pusl_board.sv
// Board-side model: external pull-ups on the strap pins, floating pins otherwise
`timescale 1ns/1ps
`default_nettype none
module pusl_board
	import pusl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Board fitting: bit0 override, 1..3 ports B..D, 4 reserved
	input wire logic [4:0] board_pullup,
	// Device pull-downs
	input wire logic strap_pulldown_en,
	input wire logic reserved_pulldown_en,
	// Strap pins
	output logic descriptor_override_strap,
	output logic port_b_detect_strap,
	output logic port_c_detect_strap,
	output logic port_d_detect_strap,
	output logic reserved_low_strap
);
	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	// Undriven pins toggle so a released pin never reads as a clean level
	logic toggle = 1'b0;
	always @(posedge clk) begin
		toggle <= !toggle;
	end
	// High through a fitted pull-up, low under the pull-down, toggling when neither holds it
	assign descriptor_override_strap = board_pullup[0] ? 1'b1 : (strap_pulldown_en ? 1'b0 : toggle);
	assign port_b_detect_strap = board_pullup[1] ? 1'b1 : (strap_pulldown_en ? 1'b0 : toggle);
	assign port_c_detect_strap = board_pullup[2] ? 1'b1 : (strap_pulldown_en ? 1'b0 : toggle);
	assign port_d_detect_strap = board_pullup[3] ? 1'b1 : (strap_pulldown_en ? 1'b0 : toggle);
	// Reserved pin held high when a scenario fits the pull-up on purpose, toggling once its pull-down is released
	assign reserved_low_strap = board_pullup[4] ? 1'b1 : (reserved_pulldown_en ? 1'b0 : toggle);
endmodule : pusl_board
`default_nettype wire

// ===== testbench/tb.sv
// Testbench: strap latching, pull-down release and registers of the strap latch
`timescale 1ns/1ps
`default_nettype none
module tb
	import pusl_pkg::*;
;
	logic clk = 1'b0;
	logic reset, psel, penable, pwrite, pready, pslverr;
	logic [PUSL_ADDR_W-1:0] paddr;
	logic [PUSL_DATA_W-1:0] pwdata, prdata, rdat;
	logic cpg, rrn, prn, bringup_done, rerr;
	logic [4:0] board_pullup;
	logic ovr_pin, pb_pin, pc_pin, pd_pin, rsv_pin, pd_en, rpd_en;
	logic sec, pb, pc, pdp, rsv_err, halt, run, rt_dis;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	always #4 clk = !clk;
	pusl_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_power_good(cpg), .resume_reset_n(rrn), .platform_reset_n(prn),
		.bringup_done(bringup_done), .descriptor_override_strap(ovr_pin),
		.port_b_detect_strap(pb_pin), .port_c_detect_strap(pc_pin), .port_d_detect_strap(pd_pin),
		.reserved_low_strap(rsv_pin), .strap_pulldown_en(pd_en), .reserved_pulldown_en(rpd_en),
		.security_override(sec), .port_b_present(pb), .port_c_present(pc), .port_d_present(pdp),
		.reserved_strap_error(rsv_err), .mgmt_halt(halt), .mgmt_run(run),
		.runtime_mgmt_disable(rt_dis));
	pusl_board u_board (.clk(clk), .board_pullup(board_pullup), .strap_pulldown_en(pd_en),
		.reserved_pulldown_en(rpd_en), .descriptor_override_strap(ovr_pin),
		.port_b_detect_strap(pb_pin), .port_c_detect_strap(pc_pin), .port_d_detect_strap(pd_pin),
		.reserved_low_strap(rsv_pin));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task tally_and_finish;
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task cyc_wait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc_wait
	// Waits on pready with a bound; no fixed slave latency is assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) n_errors++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One power-good cycle with board pull-ups m on override and ports B..D
	task latch(input logic [3:0] m);
		@(posedge clk);
		cpg <= 1'b0;
		prn <= 1'b0;
		cyc_wait(3);
		check(32'(pd_en), 32'h1);
		@(posedge clk);
		board_pullup[3:0] <= m;
		cpg <= 1'b1;
		cyc_wait(3);
		check(32'({pdp, pc, pb, sec}), 32'(m));
		@(posedge clk);
		bringup_done <= 1'b1;
		@(posedge clk);
		bringup_done <= 1'b0;
		cyc_wait(2);
		check(32'({halt, rt_dis, run}), 32'({m[0], m[0], !m[0]}));
		@(posedge clk);
		prn <= 1'b1;
		board_pullup[3:0] <= ~m;
		cyc_wait(4);
		check(32'(pd_en), 32'h0);
		check(32'({pdp, pc, pb, sec}), 32'(m));
	endtask : latch
	// ----------------------------------------
	// Timeout and main sequence
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, cpg, rrn, prn, bringup_done} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		board_pullup = 5'h00;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		cyc_wait(2);
		check(32'({pd_en, rpd_en}), 32'h3);
		check(32'({sec, pb, pc, pdp, rsv_err, halt, run}), 32'h0);
		apb(1'b0, PUSL_CTRL_OFS, 32'h0);
		check(rdat, 32'h1);
		apb(1'b0, 8'h0C, 32'h0);
		check(32'(rerr), 32'h1);
		check(rdat, 32'h0);
		@(posedge clk);
		rrn <= 1'b1;
		cyc_wait(3);
		check(32'({rpd_en, rsv_err}), 32'h0);
		for (int i = 15; i >= 0; i--) begin
			latch(4'(i));
		end
		@(posedge clk);
		rrn <= 1'b0;
		cyc_wait(3);
		check(32'(rpd_en), 32'h1);
		@(posedge clk);
		board_pullup[4] <= 1'b1;
		rrn <= 1'b1;
		cyc_wait(3);
		check(32'({rpd_en, rsv_err}), 32'h1);
		apb(1'b0, PUSL_STATUS_OFS, 32'h0);
		check(32'(rdat[PUSL_ST_RESERVED]), 32'h1);
		apb(1'b1, PUSL_ERR_OFS, 32'h1);
		apb(1'b0, PUSL_ERR_OFS, 32'h0);
		check(rdat, 32'h0);
		apb(1'b1, PUSL_CTRL_OFS, 32'h0);
		cyc_wait(2);
		check(32'({run, halt}), 32'h0);
		tally_and_finish;
	end
endmodule : tb
`default_nettype wire
